// *** src/crf_flag_status.sv ***
// receiver flag and status logic of a can controller
// assumes: tallies, overrun and fifo signals come from logic on clk_i,
// bus activity comes from the pin and is synchronised here
//
// Overview of operation
// - writing 1 clears a flag, 0 does nothing; state fields are read-only
// - in init mode the four flag bits hold reset value and the register rejects writes
// - once request and acknowledge are both 0, writes are accepted again
// - init mode leaves the receiver and transmitter state fields alone
// - bus activity in sleep with wake detect enabled sets the wake flag
// - wake flag with its enable keeps the wake-up request high
// - a change of bus status from the tallies sets the status change flag
// - status change or overrun flag, if enabled, hold the error request
// - state fields freeze while the status change flag is pending
// - receiver field: 00 up to 96, 01 to 127, 10 above, 11 bus-off
// - transmitter field shows transmit status, updated with the change flag
// - bus-off also shows in receiver field; leaving it returns to healthy
// - a receive overrun sets the overrun flag
// - shifting a good message into the foreground slot sets receive full
// - no shift into the foreground slot while receive full is set
// - receive full with its enable keeps the receive request high
// - a clear is ignored while the setting condition is still present
// - each flag is gated by its own enable bit before it requests
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`include "crf_defs.svh"
module crf_flag_status
#(
  parameter int ADDR_W = 8,
  parameter int TX_CNT_W = 9,
  parameter int RX_CNT_W = 8
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // mode control
  input wire logic init_request_i,
  input wire logic init_acknowledge_i,
  input wire logic sleep_mode_i,
  input wire logic wake_detect_enable_i,
  // can bus pin activity
  input wire logic bus_activity_i,
  // error tallies
  input wire logic [TX_CNT_W-1:0] tx_fault_tally_i,
  input wire logic [RX_CNT_W-1:0] rx_fault_tally_i,
  // receive fifo
  input wire logic overrun_event_i,
  input wire logic fifo_pending_i,
  output logic fg_shift_o,
  // interrupt requests
  output logic wake_irq_o,
  output logic error_irq_o,
  output logic rx_irq_o
);
  import crf_pkg::*;

  // ----------------------------------------------------------------
  // mode decode and register access
  // ----------------------------------------------------------------
  logic init_active;
  logic write_open;
  logic flag_wr;
  logic ie_wr;

  assign init_active = init_request_i && init_acknowledge_i;
  // the half-way handshake states count as closed for writes
  assign write_open = !init_request_i && !init_acknowledge_i;
  assign flag_wr = wr_i && write_open && (addr_i == ADDR_W'(`CRF_ADDR_FLAG));
  assign ie_wr = wr_i && write_open && (addr_i == ADDR_W'(`CRF_ADDR_IRQ_EN));

  // ----------------------------------------------------------------
  // wake detection
  // ----------------------------------------------------------------
  logic activity_sync;
  logic wake_set;

  crf_sync2 u_act_sync
  (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i(bus_activity_i),
    .q_o(activity_sync)
  );

  assign wake_set = sleep_mode_i && wake_detect_enable_i && activity_sync;

  // ----------------------------------------------------------------
  // bus status from the tallies
  // ----------------------------------------------------------------
  logic tx_bus_off;
  crf_errst_e live_tx;
  crf_errst_e live_rx;
  crf_errst_e rx_target;
  crf_errst_e rst_ff;
  crf_errst_e tst_ff;
  logic status_change;

  assign tx_bus_off = tx_fault_tally_i > TX_CNT_W'(`CRF_BUSOFF_LIMIT);

  crf_state_map #(.CNT_W(TX_CNT_W)) u_tx_map
  (
    .count_i(tx_fault_tally_i),
    .bus_off_i(tx_bus_off),
    .state_o(live_tx)
  );

  // the receive tally is widened so both maps share the same limits
  crf_state_map #(.CNT_W(TX_CNT_W)) u_rx_map
  (
    .count_i(TX_CNT_W'(rx_fault_tally_i)),
    .bus_off_i(tx_bus_off),
    .state_o(live_rx)
  );

  // leaving bus-off skips straight to healthy, whatever the rx tally says
  assign rx_target = (rst_ff == crf_busoff && !tx_bus_off) ? crf_healthy : live_rx;

  // ----------------------------------------------------------------
  // status change flag and frozen state fields
  // ----------------------------------------------------------------
  logic csc_ff;

  // a pending flag blocks detection, so later changes wait for the clear
  assign status_change = !csc_ff && ((rx_target != rst_ff) || (live_tx != tst_ff));

  // fields are not touched by init mode, only by the blocking flag
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      rst_ff <= crf_healthy;
      tst_ff <= crf_healthy;
    end
    else if (status_change)
    begin
      rst_ff <= rx_target;
      tst_ff <= live_tx;
    end
  end

  // ----------------------------------------------------------------
  // foreground slot shift
  // ----------------------------------------------------------------
  logic rxf_ff;
  logic shift_set;
  logic fg_shift_ff;

  // the fifo holds only messages that passed id, crc and error checks
  assign shift_set = fifo_pending_i && !rxf_ff && !init_active;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      fg_shift_ff <= 1'b0;
    else
      fg_shift_ff <= shift_set;
  end

  assign fg_shift_o = fg_shift_ff;

  // ----------------------------------------------------------------
  // sticky flags, one slice per flag
  // ----------------------------------------------------------------
  localparam int FLAG_N = 4;
  localparam int flag_pos [FLAG_N] = '{`CRF_WAKE_BIT, `CRF_CSC_BIT, `CRF_OVR_BIT, `CRF_RXF_BIT};
  logic [FLAG_N-1:0] flag_set;
  logic [FLAG_N-1:0] flag_ff;

  assign flag_set = {wake_set, status_change, overrun_event_i, shift_set};

  generate
    for (genvar k = 0; k < FLAG_N; k++)
    begin : g_flag
      logic nxt_flag;
      always_comb
      begin
        if (init_active)
          nxt_flag = 1'b0;
        else if (flag_set[FLAG_N-1-k])
          nxt_flag = 1'b1;
        else if (flag_wr && wdata_i[flag_pos[k]])
          nxt_flag = 1'b0;
        else
          nxt_flag = flag_ff[FLAG_N-1-k];
      end
      always_ff @(posedge clk_i)
      begin
        if (!nrst_i)
          flag_ff[FLAG_N-1-k] <= 1'b0;
        else
          flag_ff[FLAG_N-1-k] <= nxt_flag;
      end
    end
  endgenerate

  assign csc_ff = flag_ff[2];
  assign rxf_ff = flag_ff[0];

  // ----------------------------------------------------------------
  // interrupt enable register
  // ----------------------------------------------------------------
  logic [7:0] ie_ff;
  logic [7:0] ie_mask;

  assign ie_mask = (8'h01 << `CRF_WAKE_BIT) | (8'h01 << `CRF_CSC_BIT)
                 | (8'h01 << `CRF_OVR_BIT) | (8'h01 << `CRF_RXF_BIT);

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      ie_ff <= `CRF_IRQ_EN_RST;
    else if (init_active)
      ie_ff <= `CRF_IRQ_EN_RST;
    else if (ie_wr)
      ie_ff <= wdata_i & ie_mask;
  end

  // ----------------------------------------------------------------
  // interrupt requests
  // ----------------------------------------------------------------
  logic wake_irq_ff;
  logic error_irq_ff;
  logic rx_irq_ff;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      wake_irq_ff <= 1'b0;
      error_irq_ff <= 1'b0;
      rx_irq_ff <= 1'b0;
    end
    else
    begin
      wake_irq_ff <= flag_ff[3] && ie_ff[`CRF_WAKE_BIT];
      error_irq_ff <= (csc_ff && ie_ff[`CRF_CSC_BIT])
                   || (flag_ff[1] && ie_ff[`CRF_OVR_BIT]);
      rx_irq_ff <= rxf_ff && ie_ff[`CRF_RXF_BIT];
    end
  end

  assign wake_irq_o = wake_irq_ff;
  assign error_irq_o = error_irq_ff;
  assign rx_irq_o = rx_irq_ff;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0] flag_view;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  always_comb
  begin
    flag_view = `CRF_FLAG_RST;
    flag_view[`CRF_WAKE_BIT] = flag_ff[3];
    flag_view[`CRF_CSC_BIT] = csc_ff;
    flag_view[`CRF_RST_HI:`CRF_RST_LO] = rst_ff;
    flag_view[`CRF_TST_HI:`CRF_TST_LO] = tst_ff;
    flag_view[`CRF_OVR_BIT] = flag_ff[1];
    flag_view[`CRF_RXF_BIT] = rxf_ff;
  end

  always_comb
  begin
    nxt_rdata = 8'h00;
    if (rd_i && addr_i == ADDR_W'(`CRF_ADDR_FLAG))
      nxt_rdata = flag_view;
    else if (rd_i && addr_i == ADDR_W'(`CRF_ADDR_IRQ_EN))
      nxt_rdata = ie_ff;
  end

  // data stand for one cycle only and return to zero after
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= nxt_rdata;
  end

  assign rdata_o = rdata_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  chk_clear_by_one: assert property (
    flag_wr && wdata_i[`CRF_OVR_BIT] && !overrun_event_i && !init_active |=> !flag_ff[1])
    else $error("overrun flag not cleared by a written one");
  chk_zero_keeps: assert property (
    flag_wr && !wdata_i[`CRF_RXF_BIT] && rxf_ff && !init_active |=> rxf_ff)
    else $error("receive full flag lost on a written zero");
  chk_init_hold: assert property (
    init_active |=> flag_ff == '0 && ie_ff == `CRF_IRQ_EN_RST)
    else $error("flags not held at reset in init mode");
  chk_write_reopen: assert property (
    ie_wr ##1 !init_active |-> ie_ff == ($past(wdata_i) & ie_mask))
    else $error("enable write not taken after init mode");
  chk_init_fields: assert property (
    init_active && !csc_ff && live_tx != tst_ff |=> tst_ff == $past(live_tx))
    else $error("state field stopped tracking in init mode");
  chk_wake_set: assert property (
    wake_set && !init_active |=> flag_ff[3])
    else $error("wake flag not set on bus activity");
  chk_wake_irq: assert property (
    flag_ff[3] && ie_ff[`CRF_WAKE_BIT] |=> wake_irq_o)
    else $error("wake request missing");
  chk_change_sets: assert property (
    !csc_ff && !init_active && (rx_target != rst_ff) |=> csc_ff ##0 rst_ff == $past(rx_target))
    else $error("status change not flagged");
  chk_error_irq: assert property (
    (flag_ff[1] && ie_ff[`CRF_OVR_BIT]) || (csc_ff && ie_ff[`CRF_CSC_BIT]) |=> error_irq_o)
    else $error("error request missing");
  chk_field_freeze: assert property (
    csc_ff |=> $stable(rst_ff) && $stable(tst_ff))
    else $error("state field moved while change pending");
  chk_rx_coding: assert property (
    !csc_ff && !tx_bus_off && rst_ff != crf_busoff && rx_fault_tally_i > RX_CNT_W'(`CRF_PASSIVE_LIMIT)
    |=> rst_ff == crf_passive)
    else $error("receiver field wrong above passive limit");
  chk_tx_coding: assert property (
    !csc_ff && tx_fault_tally_i > TX_CNT_W'(`CRF_WARN_LIMIT)
    && tx_fault_tally_i <= TX_CNT_W'(`CRF_PASSIVE_LIMIT) |=> tst_ff == crf_warning)
    else $error("transmitter field wrong in warning band");
  chk_busoff_exit: assert property (
    !csc_ff && rst_ff == crf_busoff && !tx_bus_off |=> rst_ff == crf_healthy)
    else $error("receiver field did not return to healthy");
  chk_overrun_set: assert property (
    overrun_event_i && !init_active |=> flag_ff[1])
    else $error("overrun flag not set");
  chk_shift_sets: assert property (
    shift_set |=> fg_shift_o && rxf_ff)
    else $error("shift did not set receive full");
  chk_no_shift: assert property (
    rxf_ff |=> !fg_shift_o)
    else $error("shift while receive full set");
  chk_rx_irq: assert property (
    rxf_ff && ie_ff[`CRF_RXF_BIT] |=> rx_irq_o)
    else $error("receive request missing");
  chk_set_wins: assert property (
    flag_wr && wdata_i[`CRF_WAKE_BIT] && wake_set && !init_active |=> flag_ff[3])
    else $error("clear won over an active set");
  chk_mask_gates: assert property (
    !ie_ff[`CRF_RXF_BIT] && !ie_ff[`CRF_WAKE_BIT] |=> !rx_irq_o && !wake_irq_o)
    else $error("request raised while masked");
  chk_tx_busoff: assert property (
    !csc_ff && tx_bus_off |=> tst_ff == crf_busoff && rst_ff == crf_busoff)
    else $error("bus-off not shown in both fields");

  cov_rx_cycle: cover property (shift_set ##1 rxf_ff ##[1:20] flag_wr && wdata_i[`CRF_RXF_BIT]);
  cov_busoff: cover property (rst_ff == crf_busoff ##[1:50] rst_ff == crf_healthy);
  cov_wake: cover property (wake_set ##1 wake_irq_o [*2]);
  cov_init: cover property (init_active ##[1:10] ie_wr);

endmodule

// *** src/crf_defs.svh ***
// constants of the can receiver flag and status block
// assumes: included by bare name, holds definitions only
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CRF_ADDR_FLAG 8'h00
`define CRF_ADDR_IRQ_EN 8'h01

// ----------------------------------------------------------------
// field positions in the flag register and the enable register
// ----------------------------------------------------------------
`define CRF_WAKE_BIT 7
`define CRF_CSC_BIT 6
`define CRF_RST_HI 5
`define CRF_RST_LO 4
`define CRF_TST_HI 3
`define CRF_TST_LO 2
`define CRF_OVR_BIT 1
`define CRF_RXF_BIT 0

// ----------------------------------------------------------------
// reset values and error tally limits
// ----------------------------------------------------------------
`define CRF_FLAG_RST 8'h00
`define CRF_IRQ_EN_RST 8'h00
`define CRF_WARN_LIMIT 9'h060
`define CRF_PASSIVE_LIMIT 9'h07f
`define CRF_BUSOFF_LIMIT 9'h0ff

`endif

// *** src/crf_pkg.sv ***
// types of the can receiver flag and status block
// assumes: compiled before every module of the block
package crf_pkg;

  // bus status coding of the receiver and transmitter state fields
  typedef enum logic [1:0] {
    crf_healthy,
    crf_warning,
    crf_passive,
    crf_busoff
  } crf_errst_e;

endpackage

// *** src/crf_sync2.sv ***
// two flip-flop synchroniser for one level from a pin
// assumes: level changes slowly against clk_i
`timescale 1ns/1ns
module crf_sync2
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // level
  input wire logic d_i,
  output logic q_o
);

  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;

endmodule

// *** src/crf_state_map.sv ***
// maps an error tally onto the two-bit bus status coding
// assumes: count is zero-extended to nine bits by the caller
`timescale 1ns/1ns
`include "crf_defs.svh"
module crf_state_map
#(
  parameter int CNT_W = 9
)
(
  // tally in
  input wire logic [CNT_W-1:0] count_i,
  input wire logic bus_off_i,
  // coded status out
  output crf_pkg::crf_errst_e state_o
);
  import crf_pkg::*;

  always_comb
  begin
    if (bus_off_i)
      state_o = crf_busoff;
    else if (count_i > CNT_W'(`CRF_PASSIVE_LIMIT))
      state_o = crf_passive;
    else if (count_i > CNT_W'(`CRF_WARN_LIMIT))
      state_o = crf_warning;
    else
      state_o = crf_healthy;
  end

endmodule

// *** tb/crf_fifo_model.sv ***
// far side of the block: a small receive fifo holding good messages only
// assumes: bench pushes messages on clk_i, block consumes on fg_shift_i
`timescale 1ns/1ns
module crf_fifo_model
#(
  parameter int DEPTH = 2
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // bench commands
  input wire logic push_i,
  input wire logic hold_ovr_i,
  // block side
  input wire logic fg_shift_i,
  output logic fifo_pending_o,
  output logic overrun_o
);
  int cnt_ff = 0;
  logic ovr_ff = 1'b0;

  // ----------------------------------------
  // queue
  // ----------------------------------------
  // a message arriving at a full fifo is lost, reported as overrun
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      cnt_ff <= 0;
      ovr_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= cnt_ff + int'(push_i && cnt_ff < DEPTH) - int'(fg_shift_i);
      ovr_ff <= hold_ovr_i || (push_i && cnt_ff == DEPTH);
    end
  end

  // only qualified messages are queued; an entry leaves after its shift
  assign fifo_pending_o = cnt_ff != 0;
  assign overrun_o = ovr_ff;
endmodule

// *** tb/crf_flag_status_tb.sv ***
// testbench of the can receiver flag and status block
// assumes: design files and the fifo model are compiled before it
`timescale 1ns/1ns
`include "crf_defs.svh"
module crf_flag_status_tb;
  import crf_pkg::*;
  logic clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, d;
  logic init_request_i = 1'b0, init_acknowledge_i = 1'b0;
  logic sleep_mode_i = 1'b0, wake_detect_enable_i = 1'b0, bus_activity_i = 1'b0;
  logic [8:0] tx_fault_tally_i = 9'h000;
  logic [7:0] rx_fault_tally_i = 8'h00;
  logic overrun_event_i, fifo_pending_i, fg_shift_o;
  logic wake_irq_o, error_irq_o, rx_irq_o;
  logic push = 1'b0, hold_ovr = 1'b0, rd_seen = 1'b0, csc;
  logic [3:0] fld = 4'h0;
  logic [7:0] expq[$];
  int error_cnt = 0, compares = 0, seed = 3420, shifts = 0;
  logic [7:0] trx [9] = '{8'h60, 8'h61, 8'h7f, 8'h80, 8'h00, 8'hc8, 8'hc8, 8'hc8, 8'h00};
  logic [8:0] ttx [9] = '{9'h060, 9'h061, 9'h07f, 9'h080, 9'h0ff, 9'h100, 9'h000, 9'h000, 9'h000};
  logic [3:0] tst [9] = '{4'h0, 4'h5, 4'h5, 4'ha, 4'h2, 4'hf, 4'h0, 4'h8, 4'h0};

  crf_flag_status uut
  (
    .clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .init_request_i, .init_acknowledge_i, .sleep_mode_i, .wake_detect_enable_i,
    .bus_activity_i, .tx_fault_tally_i, .rx_fault_tally_i,
    .overrun_event_i, .fifo_pending_i, .fg_shift_o,
    .wake_irq_o, .error_irq_o, .rx_irq_o
  );

  crf_fifo_model far
  (
    .clk_i, .nrst_i, .push_i(push), .hold_ovr_i(hold_ovr),
    .fg_shift_i(fg_shift_o), .fifo_pending_o(fifo_pending_i), .overrun_o(overrun_event_i)
  );

  always #20 clk_i = ~clk_i;

  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD rdata expected %h seen %h", e, g);
    end
  endtask

  task automatic cmp_lvl(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask

  // read data stand only in the cycle after the strobe, else 0
  always @(posedge clk_i)
  begin
    if (rd_seen)
      cmp_rd(expq.pop_front(), rdata_o);
    else if (nrst_i)
      cmp_rd(8'h00, rdata_o);
    rd_seen <= rd_i;
    if (fg_shift_o === 1'b1)
      shifts++;
  end

  // ----------------------------------------
  // bus and helpers
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    expq.push_back(e);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  function automatic logic [7:0] fl(input logic w, input logic c, input logic o, input logic r);
    return {w, c, fld, o, r};
  endfunction

  task automatic complete_run;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    tick(5000);
    error_cnt++;
    complete_run();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    tick(16);
    nrst_i <= 1'b1;
    rd(`CRF_ADDR_FLAG, 8'h00);
    rd(`CRF_ADDR_IRQ_EN, 8'h00);
    wr(8'h05, 8'($random(seed)));
    rd(8'h05, 8'h00);
    // random enables; bits 5-2 always read 0
    repeat (6)
    begin
      d = 8'($random(seed));
      wr(`CRF_ADDR_IRQ_EN, d);
      rd(`CRF_ADDR_IRQ_EN, d & 8'hc3);
    end
    wr(`CRF_ADDR_IRQ_EN, 8'hc3);
    // status coding at every boundary, bus-off entry and exit
    for (int i = 0; i < 9; i++)
    begin
      rx_fault_tally_i <= trx[i];
      tx_fault_tally_i <= ttx[i];
      tick(3);
      csc = tst[i] != fld;
      fld = tst[i];
      wr(`CRF_ADDR_FLAG, 8'h3c);
      rd(`CRF_ADDR_FLAG, fl(1'b0, csc, 1'b0, 1'b0));
      #1 cmp_lvl("error_irq", csc, error_irq_o);
      wr(`CRF_ADDR_FLAG, 8'h40);
    end
    // fields freeze while the change flag is pending
    rx_fault_tally_i <= 8'h64;
    tick(3);
    fld = 4'h4;
    rx_fault_tally_i <= 8'hc8;
    tick(3);
    rd(`CRF_ADDR_FLAG, fl(1'b0, 1'b1, 1'b0, 1'b0));
    wr(`CRF_ADDR_FLAG, 8'h40);
    tick(3);
    fld = 4'h8;
    rd(`CRF_ADDR_FLAG, fl(1'b0, 1'b1, 1'b0, 1'b0));
    rx_fault_tally_i <= 8'h00;
    wr(`CRF_ADDR_FLAG, 8'h40);
    tick(3);
    fld = 4'h0;
    wr(`CRF_ADDR_FLAG, 8'h40);
    tick(3);
    rd(`CRF_ADDR_FLAG, 8'h00);
    // receive full, blocked shift and overrun
    push <= 1'b1;
    tick(1);
    push <= 1'b0;
    tick(3);
    rd(`CRF_ADDR_FLAG, fl(1'b0, 1'b0, 1'b0, 1'b1));
    #1 cmp_lvl("rx_irq", 1'b1, rx_irq_o);
    push <= 1'b1;
    tick(3);
    push <= 1'b0;
    tick(3);
    rd(`CRF_ADDR_FLAG, fl(1'b0, 1'b0, 1'b1, 1'b1));
    #1 cmp_lvl("error_irq", 1'b1, error_irq_o);
    cmp_lvl("one shift", 1'b1, shifts == 1);
    wr(`CRF_ADDR_FLAG, 8'h03);
    tick(3);
    rd(`CRF_ADDR_FLAG, fl(1'b0, 1'b0, 1'b0, 1'b1));
    #1 cmp_lvl("error_irq", 1'b0, error_irq_o);
    cmp_lvl("two shifts", 1'b1, shifts == 2);
    // clear refused while the overrun condition stays
    hold_ovr <= 1'b1;
    tick(2);
    wr(`CRF_ADDR_FLAG, 8'h02);
    rd(`CRF_ADDR_FLAG, fl(1'b0, 1'b0, 1'b1, 1'b1));
    hold_ovr <= 1'b0;
    tick(2);
    wr(`CRF_ADDR_FLAG, 8'h02);
    wr(`CRF_ADDR_IRQ_EN, 8'h00);
    tick(2);
    #1 cmp_lvl("rx_irq", 1'b0, rx_irq_o);
    wr(`CRF_ADDR_FLAG, 8'h01);
    tick(3);
    wr(`CRF_ADDR_FLAG, 8'h01);
    tick(3);
    rd(`CRF_ADDR_FLAG, 8'h00);
    cmp_lvl("three shifts", 1'b1, shifts == 3);
    // wake-up only with detection enabled
    wr(`CRF_ADDR_IRQ_EN, 8'h80);
    sleep_mode_i <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      wake_detect_enable_i <= 1'(k);
      bus_activity_i <= 1'b1;
      tick(5);
      // a clear while the activity still stands must lose to the set
      wr(`CRF_ADDR_FLAG, 8'h80);
      bus_activity_i <= 1'b0;
      tick(4);
      rd(`CRF_ADDR_FLAG, {1'(k), 7'h00});
      #1 cmp_lvl("wake_irq", 1'(k), wake_irq_o);
    end
    wr(`CRF_ADDR_FLAG, 8'h80);
    sleep_mode_i <= 1'b0;
    tick(2);
    rd(`CRF_ADDR_FLAG, 8'h00);
    #1 cmp_lvl("wake_irq", 1'b0, wake_irq_o);
    // init mode: flags held, writes refused, fields keep tracking
    rx_fault_tally_i <= 8'h64;
    wr(`CRF_ADDR_IRQ_EN, 8'hc3);
    tick(3);
    fld = 4'h4;
    init_request_i <= 1'b1;
    tick(1);
    init_acknowledge_i <= 1'b1;
    tick(2);
    rd(`CRF_ADDR_FLAG, fl(1'b0, 1'b0, 1'b0, 1'b0));
    wr(`CRF_ADDR_IRQ_EN, 8'hff);
    rd(`CRF_ADDR_IRQ_EN, 8'h00);
    rx_fault_tally_i <= 8'h00;
    tx_fault_tally_i <= 9'h061;
    tick(3);
    fld = 4'h1;
    rd(`CRF_ADDR_FLAG, fl(1'b0, 1'b0, 1'b0, 1'b0));
    init_request_i <= 1'b0;
    wr(`CRF_ADDR_IRQ_EN, 8'hff);
    rd(`CRF_ADDR_IRQ_EN, 8'h00);
    init_acknowledge_i <= 1'b0;
    wr(`CRF_ADDR_IRQ_EN, 8'h41);
    rd(`CRF_ADDR_IRQ_EN, 8'h41);
    tick(3);
    complete_run();
  end
endmodule
